/* File: btb_cfg.svh */
// Constants for the bit-toggle and flag-branch execute block
`ifndef BTB_CFG_SVH
`define BTB_CFG_SVH
`define BTB_OP_TOGGLE 4'h7
`define BTB_OP_BR_OVF 8'hE4
`define BTB_OP_BR_ZERO 8'hE0
`define BTB_IDX_LIMIT 8'h5F
`define BTB_PC_W 21
`define BTB_ADDR_W 12
`define BTB_STEP 21'h000002
`define BTB_ACCESS_SPLIT 8'h60
`define BTB_ACCESS_HIGH 4'hF
`define BTB_ACCESS_LOW 4'h0
`endif

/* File: btb_pkg.sv */
// Types for the bit-toggle and flag-branch execute block
package btb_pkg;
  typedef enum logic [1:0] {
    BTB_Q1 = 2'b00,
    BTB_Q2 = 2'b01,
    BTB_Q3 = 2'b10,
    BTB_Q4 = 2'b11
  } btb_phase_t;
  typedef enum logic [1:0] {
    BTB_K_NONE = 2'b00,
    BTB_K_TOGGLE = 2'b01,
    BTB_K_BRANCH = 2'b10
  } btb_kind_t;
endpackage : btb_pkg

/* File: btb_addr.sv */
// Operand address generator for byte and bit instructions
`timescale 1ns/1ps
`default_nettype none
`include "btb_cfg.svh"
module btb_addr
  import btb_pkg::*;
(
  input wire logic [7:0] file_addr,
  input wire logic bank_sel,
  input wire logic ext_en,
  input wire logic [3:0] bank_select_register,
  input wire logic [11:0] index_base,
  output logic [11:0] eff_addr
);
  always_comb begin
    if (!bank_sel && ext_en && file_addr <= `BTB_IDX_LIMIT) begin
      eff_addr = index_base + {4'h0, file_addr};
    end else if (bank_sel) begin
      eff_addr = {bank_select_register, file_addr};
    end else if (file_addr < `BTB_ACCESS_SPLIT) begin
      eff_addr = {`BTB_ACCESS_LOW, file_addr};
    end else begin
      eff_addr = {`BTB_ACCESS_HIGH, file_addr};
    end
  end
endmodule : btb_addr
`default_nettype wire

/* File: btb_exec.sv */
// Decode and execute of bit toggle and flag branches over four phases
`timescale 1ns/1ps
`default_nettype none
`include "btb_cfg.svh"
// Contract
// - Toggle opcode 0111, bit, bank, file
// - Invert chosen bit, write back, flags kept
// - Bank bit selects access or banked data
// - Extended mode low addresses use indexed offset when bank bit is clear
// - Overflow branch opcode E4, signed offset
// - Overflow branch taken only when overflow set
// - Target is incremented PC plus twice offset
// - Branch one cycle, two when taken
// - Taken zero branch jumps, flags kept
module btb_exec
  import btb_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] instr,
  input wire logic [20:0] pc_inc,
  input wire logic flag_ovf,
  input wire logic flag_zero,
  input wire logic ext_en,
  input wire logic [3:0] bank_select_register,
  input wire logic [11:0] index_base,
  input wire logic [7:0] mem_rdata,
  output logic [1:0] phase,
  output logic [11:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  output logic pc_wr,
  output logic [20:0] pc_wdata,
  output logic flush,
  output logic instr_done
);
  btb_phase_t phase_reg, phase_next;
  btb_kind_t kind_reg, kind_next;
  logic [15:0] ir_reg, ir_next;
  logic [7:0] data_reg, data_next;
  logic take_reg, take_next;
  logic nop_reg, nop_next;
  logic [11:0] addr_reg, addr_next;
  logic rd_reg, rd_next;
  logic wr_reg, wr_next;
  logic [7:0] wdata_reg, wdata_next;
  logic pcw_reg, pcw_next;
  logic [20:0] pcd_reg, pcd_next;
  logic flush_reg, flush_next;
  logic done_reg, done_next;
  logic [11:0] eff_addr;
  logic [7:0] flip_mask;

  function automatic btb_kind_t decode_kind(input logic [15:0] w);
    if (w[15:12] == `BTB_OP_TOGGLE) begin
      decode_kind = BTB_K_TOGGLE;
    end else if (w[15:8] == `BTB_OP_BR_OVF || w[15:8] == `BTB_OP_BR_ZERO) begin
      decode_kind = BTB_K_BRANCH;
    end else begin
      decode_kind = BTB_K_NONE;
    end
  endfunction : decode_kind

  // Taken branch: writes the PC and idles the following cycle
  function automatic logic is_jump(input btb_kind_t k, input logic t);
    is_jump = (k == BTB_K_BRANCH) && t;
  endfunction : is_jump

  btb_addr u_addr (
    .file_addr(ir_reg[7:0]),
    .bank_sel(ir_reg[8]),
    .ext_en(ext_en),
    .bank_select_register(bank_select_register),
    .index_base(index_base),
    .eff_addr(eff_addr)
  );

  // One select per data bit; keeps the toggle a plain XOR
  generate
    for (genvar gi = 0; gi < 8; gi++) begin : g_flip
      assign flip_mask[gi] = (ir_reg[11:9] == 3'(gi));
    end
  endgenerate

  // Sequencing: phase count, decode and the idle cycle after a jump
  always_comb begin
    phase_next = btb_phase_t'(phase_reg + 2'b01);
    kind_next = kind_reg;
    ir_next = ir_reg;
    nop_next = nop_reg;
    done_next = 1'b0;
    unique case (phase_reg)
      BTB_Q1: begin
        // Decode; a taken branch spends the whole next cycle idle
        if (nop_reg) begin
          kind_next = BTB_K_NONE;
        end else begin
          ir_next = instr;
          kind_next = decode_kind(instr);
        end
      end
      BTB_Q2: begin
        // Operand read lives in the datapath group
      end
      BTB_Q3: begin
        // Processing lives in the datapath group
      end
      BTB_Q4: begin
        nop_next = is_jump(kind_reg, take_reg);
        // The idle cycle reports nothing, so fetch can count words
        done_next = !nop_reg;
      end
    endcase
  end

  // Synchronous reset only; no clock enable anywhere
  always_ff @(posedge clk) begin
    if (rst) begin
      phase_reg <= BTB_Q1;
      kind_reg <= BTB_K_NONE;
      ir_reg <= 16'h0000;
      nop_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      kind_reg <= kind_next;
      ir_reg <= ir_next;
      nop_reg <= nop_next;
      done_reg <= done_next;
    end
  end

  // Datapath: operand read, toggle and branch target
  always_comb begin
    data_next = data_reg;
    take_next = take_reg;
    addr_next = addr_reg;
    rd_next = 1'b0;
    wr_next = 1'b0;
    wdata_next = wdata_reg;
    pcw_next = 1'b0;
    pcd_next = pcd_reg;
    flush_next = 1'b0;
    unique case (phase_reg)
      BTB_Q1: begin
        // Decode lives in the sequencing group
      end
      BTB_Q2: begin
        if (kind_reg == BTB_K_TOGGLE) begin
          addr_next = eff_addr;
          rd_next = 1'b1;
        end
      end
      BTB_Q3: begin
        if (kind_reg == BTB_K_TOGGLE) begin
          // Only bit b flips; status flags are never touched
          data_next = mem_rdata ^ flip_mask;
        end
        if (kind_reg == BTB_K_BRANCH) begin
          // Flags are sampled late so a prior write has settled
          take_next = (ir_reg[15:8] == `BTB_OP_BR_OVF) ?
            flag_ovf : flag_zero;
          pcd_next = pc_inc + {{12{ir_reg[7]}}, ir_reg[7:0], 1'b0};
        end
      end
      BTB_Q4: begin
        if (kind_reg == BTB_K_TOGGLE) begin
          wr_next = 1'b1;
          wdata_next = data_reg;
        end
        // Not-taken branch writes nothing in this phase
        if (is_jump(kind_reg, take_reg)) begin
          pcw_next = 1'b1;
          flush_next = 1'b1;
        end
        take_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      data_reg <= 8'h00;
      take_reg <= 1'b0;
      addr_reg <= 12'h000;
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
      wdata_reg <= 8'h00;
      pcw_reg <= 1'b0;
      pcd_reg <= 21'h000000;
      flush_reg <= 1'b0;
    end else begin
      data_reg <= data_next;
      take_reg <= take_next;
      addr_reg <= addr_next;
      rd_reg <= rd_next;
      wr_reg <= wr_next;
      wdata_reg <= wdata_next;
      pcw_reg <= pcw_next;
      pcd_reg <= pcd_next;
      flush_reg <= flush_next;
    end
  end

  // Outputs come straight from registers; no glitches on the strobes
  assign phase = phase_reg;
  assign mem_addr = addr_reg;
  assign mem_rd = rd_reg;
  assign mem_wr = wr_reg;
  assign mem_wdata = wdata_reg;
  assign pc_wr = pcw_reg;
  assign pc_wdata = pcd_reg;
  assign flush = flush_reg;
  assign instr_done = done_reg;
endmodule : btb_exec
`default_nettype wire

/* File: btb_exec_asserts.sv */
// Port assertions for the execute block
`timescale 1ns/1ps
`default_nettype none
module btb_exec_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] instr,
  input wire logic [20:0] pc_inc,
  input wire logic flag_ovf,
  input wire logic flag_zero,
  input wire logic [7:0] mem_rdata,
  input wire logic [1:0] phase,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  input wire logic pc_wr,
  input wire logic [20:0] pc_wdata,
  input wire logic flush,
  input wire logic instr_done
);
  wire [2:0] sel = instr[11:9];
  wire [7:0] op = instr[15:8];
  wire [20:0] offs = {{12{instr[7]}}, instr[7:0], 1'b0};
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  read_phase_a: assert property (mem_rd |-> phase == 2'h2)
    else $error("read off phase");
  write_follow_a: assert property (mem_rd |-> ##2 mem_wr && phase == 2'h0)
    else $error("no write back");
  toggle_data_a: assert property (mem_wr |->
    mem_wdata == ($past(mem_rdata, 2) ^ (8'h01 << $past(sel, 4)))) else $error("bad byte");
  jump_pair_a: assert property (pc_wr |-> flush && instr_done && !mem_wr)
    else $error("bad jump pulse");
  nop_gap_a: assert property (flush |=> !instr_done [*7])
    else $error("nop cycle ran");
  jump_dest_a: assert property (pc_wr |->
    pc_wdata == $past(pc_inc, 2) + $past(offs, 4)) else $error("bad target");
  ovf_take_a: assert property (instr_done && $past(op, 4) == 8'hE4 |->
    pc_wr == $past(flag_ovf, 2)) else $error("bad overflow branch");
  zero_take_a: assert property (instr_done && $past(op, 4) == 8'hE0 |->
    pc_wr == $past(flag_zero, 2)) else $error("bad zero branch");
endmodule : btb_exec_asserts
bind btb_exec btb_exec_asserts chk_i (.*);
`default_nettype wire

/* File: btb_mem_model.sv */
// Data memory seen by the execute block
`timescale 1ns/1ps
`default_nettype none
module btb_mem_model (
  input wire logic clk,
  input wire logic [11:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:4095];
  initial for (int i = 0; i < 4096; i++) mem[i] = i[7:0] ^ 8'h3C;
  // Inverted off read, so a late sample shows
  assign mem_rdata = mem_rd ? mem[mem_addr] : ~mem[mem_addr];
  always @(posedge clk) if (mem_wr) mem[mem_addr] <= mem_wdata;
endmodule : btb_mem_model
`default_nettype wire

/* File: btb_exec_tb.sv */
// Self-checking bench for the execute block
`timescale 1ns/1ps
`default_nettype none
module btb_exec_tb;
  logic clk = 0, rst = 1, flag_ovf = 0, flag_zero = 0, ext_en = 0;
  logic [15:0] instr = 16'h0000;
  logic [20:0] pc_inc = 21'h1FFF00, pc_wdata, tgt;
  logic [3:0] bank_select_register = 4'h3;
  logic [11:0] index_base = 12'hFE0, mem_addr, ea;
  logic [7:0] mem_rdata, mem_wdata;
  logic [7:0] shadow [0:4095];
  logic [1:0] phase;
  logic mem_rd, mem_wr, pc_wr, flush, instr_done, dn = 0, tg = 0, tk = 0;
  int err_total = 0, num_checks = 0, cycles = 0;
  btb_exec dut (.*);
  btb_mem_model mem (.*);
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 400) begin
      err_total++;
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  // Checks the previous instruction's pulses, then this one's read
  task automatic step(input logic [15:0] w, input logic o, z, x);
    instr <= w;
    flag_ovf <= o;
    flag_zero <= z;
    ext_en <= x;
    #1;
    chk(instr_done, dn);
    chk({mem_wr, pc_wr, flush}, {tg, tk, tk});
    if (tg) chk(mem_wdata, shadow[ea]);
    if (tk) chk(pc_wdata, tgt);
    dn = !tk;
    tg = dn && w[15:12] == 4'h7;
    tk = dn && (w[15:8] == 8'hE4 && o || w[15:8] == 8'hE0 && z);
    tgt = pc_inc + {{12{w[7]}}, w[7:0], 1'b0};
    ea = w[8] ? {bank_select_register, w[7:0]} : x && w[7:0] <= 8'h5F ?
      index_base + {4'h0, w[7:0]} : {w[7:0] < 8'h60 ? 4'h0 : 4'hF, w[7:0]};
    if (tg) shadow[ea] ^= 8'h01 << w[11:9];
    repeat (2) @(posedge clk);
    #1;
    chk(mem_rd, tg);
    if (tg) chk(mem_addr, ea);
    repeat (2) @(posedge clk);
  endtask : step
  task automatic toggle_cases();
    step(16'h7F12, 0, 0, 0);
    step(16'h705F, 0, 0, 0);
    step(16'h745F, 0, 0, 1);
    step(16'h7260, 0, 0, 1);
    step(16'h7460, 0, 0, 1);
    step(16'h7460, 0, 0, 1);
  endtask : toggle_cases
  // The word right after a taken branch is dropped
  task automatic branch_cases();
    step(16'hE480, 1, 0, 0);
    step(16'h7012, 0, 0, 0);
    step(16'hE47F, 0, 1, 0);
    step(16'hE07F, 0, 1, 0);
    step(16'hE480, 1, 0, 0);
    step(16'hE005, 1, 0, 0);
    step(16'h0000, 0, 0, 0);
  endtask : branch_cases
  initial begin
    for (int i = 0; i < 4096; i++) shadow[i] = i[7:0] ^ 8'h3C;
    repeat (2) @(posedge clk);
    rst <= 0;
    toggle_cases();
    branch_cases();
    step(16'h0000, 0, 0, 0);
    give_verdict();
  end
endmodule : btb_exec_tb
`default_nettype wire
